// ==== inc/ddrcpd_pkg.sv ====
`default_nettype none
package ddrcpd_pkg;

	// Width of the bank address pins
	localparam int BANK_W = 2;
	// Data beats in one burst (burst length four)
	localparam int BURST_BEATS = 4;
	// Width of the beat counter
	localparam int BEAT_W = 3;
	// Reset value of the beat counter
	localparam logic [2:0] BEAT_RST = 3'h0;
	// Reset value of the crossing history
	localparam logic CROSS_RST = 1'b0;

	// Command pins as sampled together; all active low
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} ddrcpd_cmd_pins_t;

	// Reset value of the command pins: deselect
	localparam ddrcpd_cmd_pins_t CMD_PINS_RST = 4'hF;

	// Decoded commands
	typedef enum logic [2:0] {
		CMD_NOP,
		CMD_ACT,
		CMD_READ,
		CMD_WRITE,
		CMD_PRE,
		CMD_REF,
		CMD_MRS
	} ddrcpd_cmd_t;

	// Power states reached through the clock enable
	typedef enum logic [1:0] {
		PWR_ON,
		PWR_PRE_PD,
		PWR_ACT_PD,
		PWR_SELF_REF
	} ddrcpd_pwr_t;

endpackage
`default_nettype wire

// ==== logic/ddrcpd_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a vector of pin inputs
module ddrcpd_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	// Asynchronous input and synchronised output
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	// First stage; only the second stage reads it
	logic [WIDTH-1:0] meta_r;

	// Refuse a width the logic cannot serve, at elaboration
	if (WIDTH < 1) begin : g_bad_width
		$error("ddrcpd_sync: WIDTH must be at least one");
	end

	// Both stages clear to zero under reset
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule
`default_nettype wire

// ==== logic/ddrcpd_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - Chip select high masks every command
// R2 - Decode chip select with the three strobes
// R3 - Drop write beats sampled with mask high
// R4 - Clock enable low picks power-down by banks
// R5 - Clock enable sampled on clock for entry
// R6 - Self refresh exit seen without clock edge
// R7 - Read beats timed on both clock crossings
// R8 - Controller keeps clock enable high during bursts
// R9 - Termination input ignored when disabled
// R10 - Deselect is a no-op, burst continues
module ddrcpd_top #(
	parameter int DQ_W = 8,
	parameter int NUM_BANKS = 4
) (
	// System clock and reset
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	// Differential memory clock pins, sampled as data
	input wire logic i_ck_p,
	input wire logic i_ck_n,
	// Control pins
	input wire logic i_cke,
	input wire ddrcpd_pkg::ddrcpd_cmd_pins_t i_cmd_pins,
	input wire logic [ddrcpd_pkg::BANK_W-1:0] i_bank,
	input wire logic i_a10,
	input wire logic i_termination_enable,
	// Write data pins
	input wire logic [DQ_W-1:0] i_dq,
	input wire logic i_write_byte_mask,
	// Mode setting and array read data, same clock
	input wire logic i_term_allowed,
	input wire logic [DQ_W-1:0] i_rd_data,
	// Decoded command
	output logic o_cmd_valid,
	output ddrcpd_pkg::ddrcpd_cmd_t o_cmd,
	output logic [ddrcpd_pkg::BANK_W-1:0] o_cmd_bank,
	// Write beats to the array
	output logic o_wr_valid,
	output logic [DQ_W-1:0] o_wr_data,
	// Read beats toward the pins
	output logic o_rd_valid,
	output logic [DQ_W-1:0] o_rd_data,
	// Device state
	output ddrcpd_pkg::ddrcpd_pwr_t o_pwr_state,
	output logic [NUM_BANKS-1:0] o_bank_open,
	output logic o_term_on
);
	import ddrcpd_pkg::*;

	// Packed pin vector width
	localparam int PIN_W = 2 + 1 + 4 + BANK_W + 1 + 1 + DQ_W + 1;

	// Refuse widths the logic cannot serve, at elaboration
	if (DQ_W < 1) begin : g_bad_dq
		$error("ddrcpd_top: DQ_W must be at least one");
	end
	// Bank tracking decodes every code of the bank pins
	if (NUM_BANKS != (1 << BANK_W)) begin : g_bad_banks
		$error("ddrcpd_top: NUM_BANKS must match bank pins");
	end

	// Synchronised pins
	logic [PIN_W-1:0] pins_s;
	logic ck_p_s;
	logic ck_n_s;
	logic cke_s;
	ddrcpd_cmd_pins_t cmd_s;
	logic [BANK_W-1:0] bank_s;
	logic a10_s;
	logic term_pin_s;
	logic [DQ_W-1:0] dq_s;
	logic mask_s;

	// All pins share one delay, so command, mask and data stay aligned
	ddrcpd_sync #(
		.WIDTH(PIN_W)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n),
		.i_async({i_ck_p, i_ck_n, i_cke, i_cmd_pins, i_bank, i_a10,
			i_termination_enable, i_dq, i_write_byte_mask}),
		.o_sync(pins_s)
	);

	assign {ck_p_s, ck_n_s, cke_s, cmd_s, bank_s, a10_s, term_pin_s, dq_s,
		mask_s} = pins_s;

	// Crossing detection; clock pair must be well below the system rate
	logic diff_r;
	logic diff_now;
	logic rise_x;
	logic fall_x;
	logic any_x;

	assign diff_now = ck_p_s & ~ck_n_s;
	// A crossing needs both legs to have swapped; equal legs leave the
	// history alone, so a leg that has moved early cannot fake a crossing
	assign rise_x = diff_now & ~diff_r;
	assign fall_x = ~ck_p_s & ck_n_s & diff_r;
	assign any_x = rise_x | fall_x; // R7

	// Crossing history follows settled levels only
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			diff_r <= CROSS_RST;
		end else if (ck_p_s ^ ck_n_s) begin
			diff_r <= diff_now;
		end
	end

	// Command decode from all four pins together
	ddrcpd_cmd_t cmd_dec;
	always_comb begin
		cmd_dec = CMD_NOP;
		if (!cmd_s.cs_n) begin // R1
			case ({cmd_s.ras_n, cmd_s.cas_n, cmd_s.we_n}) // R2
				3'h3: cmd_dec = CMD_ACT;
				3'h5: cmd_dec = CMD_READ;
				3'h4: cmd_dec = CMD_WRITE;
				3'h2: cmd_dec = CMD_PRE;
				3'h1: cmd_dec = CMD_REF;
				3'h0: cmd_dec = CMD_MRS;
				default: cmd_dec = CMD_NOP; // R10
			endcase
		end
	end

	// Commands are taken only while awake with clock enable high
	logic cmd_take;
	assign cmd_take = rise_x & cke_s & (o_pwr_state == PWR_ON);

	// Decoded command output, one-cycle pulse
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_cmd_valid <= 1'b0;
			o_cmd <= CMD_NOP;
			o_cmd_bank <= '0;
		end else begin
			o_cmd_valid <= cmd_take && (cmd_dec != CMD_NOP); // R1
			if (cmd_take) begin
				o_cmd <= cmd_dec;
				o_cmd_bank <= bank_s;
			end
		end
	end

	// Open-row tracking per bank
	genvar gb;
	generate
		for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
			always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					o_bank_open[gb] <= 1'b0;
				end else if (cmd_take) begin
					// Activate opens, precharge closes, A10 closes all
					if (cmd_dec == CMD_ACT && bank_s == BANK_W'(gb)) begin
						o_bank_open[gb] <= 1'b1;
					end else if (cmd_dec == CMD_PRE &&
						(a10_s || bank_s == BANK_W'(gb))) begin
						o_bank_open[gb] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Power state machine
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pwr_state <= PWR_ON;
		end else begin
			case (o_pwr_state)
				PWR_ON: begin
					// Entry sampled on a rising crossing only
					if (rise_x && !cke_s) begin // R5
						if (cmd_dec == CMD_REF && ~|o_bank_open) begin
							o_pwr_state <= PWR_SELF_REF; // R4
						end else if (|o_bank_open) begin
							o_pwr_state <= PWR_ACT_PD; // R4
						end else begin
							o_pwr_state <= PWR_PRE_PD; // R4
						end
					end
				end
				PWR_PRE_PD, PWR_ACT_PD: begin
					// Power-down exit also waits for a crossing
					if (rise_x && cke_s) begin // R5
						o_pwr_state <= PWR_ON;
					end
				end
				PWR_SELF_REF: begin
					// The clock may be stopped here, so the level alone wakes
					if (cke_s) begin // R6
						o_pwr_state <= PWR_ON;
					end
				end
				default: o_pwr_state <= PWR_ON;
			endcase
		end
	end

	// Burst beat counters; deselect does not touch a running burst
	logic [BEAT_W-1:0] wr_beats_r;
	logic [BEAT_W-1:0] rd_beats_r;

	// Write burst counter, loaded by a write command
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_beats_r <= BEAT_RST;
		end else if (cmd_take && cmd_dec == CMD_WRITE) begin
			wr_beats_r <= BEAT_W'(BURST_BEATS);
		end else if (any_x && wr_beats_r != BEAT_RST) begin
			wr_beats_r <= wr_beats_r - BEAT_W'(1); // R10
		end
	end

	// Read burst counter, loaded by a read command
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rd_beats_r <= BEAT_RST;
		end else if (cmd_take && cmd_dec == CMD_READ) begin
			rd_beats_r <= BEAT_W'(BURST_BEATS);
		end else if (any_x && rd_beats_r != BEAT_RST) begin
			rd_beats_r <= rd_beats_r - BEAT_W'(1); // R10
		end
	end

	// Write beats on each crossing of a burst; masked beats vanish
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_wr_valid <= 1'b0;
			o_wr_data <= '0;
		end else begin
			o_wr_valid <= any_x && wr_beats_r != BEAT_RST && !mask_s; // R3
			if (any_x && !mask_s) begin
				o_wr_data <= dq_s; // R3
			end
		end
	end

	// Read beats launched on both crossing directions
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
		end else begin
			o_rd_valid <= any_x && rd_beats_r != BEAT_RST; // R7
			if (any_x) begin
				o_rd_data <= i_rd_data; // R7
			end
		end
	end

	// Termination follows the pin only when the mode setting allows it
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_term_on <= 1'b0;
		end else begin
			// Self refresh disables this receiver as well
			o_term_on <= i_term_allowed && term_pin_s &&
				(o_pwr_state != PWR_SELF_REF); // R9
		end
	end

endmodule
`default_nettype wire

// ==== sim/ddrcpd_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the pin decode from its ports only
module ddrcpd_props #(
	parameter int NUM_BANKS = 4
) (
	// Clock, reset and pins
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_cke,
	input wire ddrcpd_pkg::ddrcpd_cmd_pins_t i_cmd_pins,
	input wire logic i_write_byte_mask,
	input wire logic i_term_allowed,
	// Outputs
	input wire logic o_cmd_valid,
	input wire logic o_wr_valid,
	input wire logic o_rd_valid,
	input wire ddrcpd_pkg::ddrcpd_pwr_t o_pwr_state,
	input wire logic [NUM_BANKS-1:0] o_bank_open,
	input wire logic o_term_on
);
	import ddrcpd_pkg::*;
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_arst_n);
	// Pins reach outputs three edges later
	a_cs_masks: assert property (
		o_cmd_valid |-> !$past(i_cmd_pins.cs_n, 3))
		else $error("command taken while deselected");
	a_cmd_one_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
		else $error("command pulse too long");
	a_mask_drops: assert property (
		o_wr_valid |-> !$past(i_write_byte_mask, 3))
		else $error("masked beat stored");
	a_act_pd_open: assert property (
		o_pwr_state == PWR_ACT_PD |-> |o_bank_open)
		else $error("active power-down with banks idle");
	a_taken_when_on: assert property (
		o_cmd_valid |-> $past(o_pwr_state) == PWR_ON)
		else $error("command taken in power-down");
	// Exit needs only the level, no crossing
	a_sr_exit_fast: assert property (
		o_pwr_state == PWR_SELF_REF && i_cke
		|-> ##[1:4] o_pwr_state == PWR_ON)
		else $error("self refresh exit late");
	a_rd_one_pulse: assert property (o_rd_valid |=> !o_rd_valid)
		else $error("read pulse too long");
	a_term_off: assert property (!i_term_allowed |=> !o_term_on)
		else $error("termination on while disabled");
endmodule
bind ddrcpd_top ddrcpd_props #(.NUM_BANKS(NUM_BANKS)) u_props (.*);
`default_nettype wire

// ==== sim/ddrcpd_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Controller model: free memory clock, pins change with crossings
module ddrcpd_ctrl_model (
	// System clock
	input wire logic i_sys_clk,
	// Pins toward the device
	output logic o_ck_p,
	output logic o_ck_n,
	output logic o_cke,
	output ddrcpd_pkg::ddrcpd_cmd_pins_t o_cmd_pins,
	output logic [1:0] o_bank,
	output logic o_a10,
	output logic [7:0] o_dq,
	output logic o_mask,
	output logic [7:0] o_rd
);
	import ddrcpd_pkg::*;
	logic [1:0] cnt_r; // Half period of four cycles, slow enough to sample
	assign o_ck_n = ~o_ck_p;
	initial begin
		{cnt_r, o_ck_p, o_cke, o_bank, o_a10, o_dq, o_mask, o_rd} = '0;
		o_cke = 1'b1;
		o_cmd_pins = CMD_PINS_RST;
	end
	// Clock toggles every fourth edge
	always @(posedge i_sys_clk) begin
		cnt_r <= cnt_r + 2'h1;
		if (cnt_r == 2'h3) o_ck_p <= ~o_ck_p;
	end
	// Command at a rise, beats on the four crossings after it
	task automatic xfer(input logic [3:0] pins, input logic [1:0] bank,
		input logic a10, input logic cke, input logic [31:0] d,
		input logic [3:0] m);
		@(posedge i_sys_clk iff (cnt_r == 2'h3 && !o_ck_p));
		o_cmd_pins <= pins;
		o_bank <= bank;
		o_a10 <= a10;
		o_cke <= cke;
		for (int i = 0; i < 4; i++) begin
			@(posedge i_sys_clk iff cnt_r == 2'h3);
			o_cmd_pins <= CMD_PINS_RST;
			o_dq <= d[8*i +: 8];
			o_mask <= m[i];
			o_rd <= d[8*i +: 8];
		end
	endtask
endmodule
`default_nettype wire

// ==== sim/tb_ddr2_control_pin_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_control_pin_decode;
	import ddrcpd_pkg::*;
	logic clk, arst_n, ck_p, ck_n, cke, a10, mask, term_ok, term_en;
	logic cv, wv, rv, ton;
	ddrcpd_cmd_pins_t pins;
	logic [1:0] bank, cbank;
	logic [7:0] dq, rd, wd, rdo;
	logic [3:0] bopen;
	logic [3:0] opn = 4'h0; // Banks we expect open
	logic pd = 1'b0; // Expect a power-down state
	logic sr = 1'b0; // Expect self refresh
	ddrcpd_cmd_t cmd;
	ddrcpd_pwr_t pwr, pst = PWR_ON;
	logic [15:0] qc[$], qw[$], qr[$], qp[$]; // Notes per kind
	int error_cnt = 0;
	int n_compared = 0;
	// Strobes {ras,cas,we} in enum order NOP..MRS
	logic [2:0] tbl [7] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
	ddrcpd_ctrl_model m_ctrl (.i_sys_clk(clk), .o_ck_p(ck_p), .o_ck_n(ck_n),
		.o_cke(cke), .o_cmd_pins(pins), .o_bank(bank), .o_a10(a10),
		.o_dq(dq), .o_mask(mask), .o_rd(rd));
	ddrcpd_top uut (.i_sys_clk(clk), .i_arst_n(arst_n), .i_ck_p(ck_p),
		.i_ck_n(ck_n), .i_cke(cke), .i_cmd_pins(pins), .i_bank(bank),
		.i_a10(a10), .i_termination_enable(term_en), .i_dq(dq),
		.i_write_byte_mask(mask), .i_term_allowed(term_ok),
		.i_rd_data(rd), .o_cmd_valid(cv), .o_cmd(cmd), .o_cmd_bank(cbank),
		.o_wr_valid(wv), .o_wr_data(wd), .o_rd_valid(rv), .o_rd_data(rdo),
		.o_pwr_state(pwr), .o_bank_open(bopen), .o_term_on(ton));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Each result takes the oldest note; an empty queue yields X
	always @(posedge clk) if (arst_n) begin
		if (cv) chk(16'({cbank, cmd}), qc.size() ? qc.pop_front() : 'x);
		if (wv) chk(16'(wd), qw.size() ? qw.pop_front() : 'x);
		if (rv) chk(16'(rdo), qr.size() ? qr.pop_front() : 'x);
		if (pwr !== pst) chk(16'(pwr), qp.size() ? qp.pop_front() : 'x);
		pst <= pwr;
	end
	// One slot: note what the device must do, then drive it
	task automatic run(input int k, input logic cs, input logic ke,
		input logic a10v);
		logic [1:0] b;
		logic [31:0] d;
		logic [3:0] m;
		b = 2'($urandom);
		d = $urandom;
		m = 4'($urandom);
		term_ok <= 1'($urandom);
		term_en <= 1'($urandom);
		if (pd) begin
			pd = !ke;
			sr = sr && !ke;
			if (ke) qp.push_back(16'(PWR_ON));
		end else if (!ke) begin
			pd = 1'b1;
			sr = !cs && k == 5 && opn == 4'h0;
			if (opn != 4'h0) qp.push_back(16'(PWR_ACT_PD));
			else if (sr) qp.push_back(16'(PWR_SELF_REF));
			else qp.push_back(16'(PWR_PRE_PD));
		end else if (!cs) begin
			if (k != 0) qc.push_back({11'h0, b, 3'(k)});
			if (k == 1) opn[b] = 1'b1;
			if (k == 4) opn = a10v ? 4'h0 : opn & ~(4'h1 << b);
			for (int i = 0; i < 4; i++) begin
				if (k == 3 && !m[i]) qw.push_back(16'(d[8*i +: 8]));
				if (k == 2) qr.push_back(16'(d[8*i +: 8]));
			end
		end
		m_ctrl.xfer({cs, tbl[k]}, b, a10v, ke, d, m);
		// Levels have settled by the end of the slot
		chk(16'({bopen, ton}), 16'({opn, term_ok & term_en & !sr}));
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Overrun guard, far beyond about 1700 cycles of tests
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	initial begin
		{arst_n, term_ok, term_en} = 3'h0;
		void'($urandom(76));
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		for (int k = 0; k < 7; k++) run(k, 1'b0, 1'b1, 1'b0);
		run(4, 1'b0, 1'b1, 1'b1);
		run(5, 1'b0, 1'b0, 1'b0);
		run(0, 1'b0, 1'b1, 1'b0);
		repeat (60) run($urandom % 7, $urandom % 4 == 0, $urandom % 4 != 0,
			1'($urandom));
		repeat (30) @(posedge clk);
		chk(16'(qc.size() + qw.size() + qr.size() + qp.size()), 16'h0);
		close_out();
	end
endmodule
`default_nettype wire
